/* hw/scu_irq_sync.sv */
/*
 * System control unit interrupt flags, enables, combined request line,
 * frequency-locked-loop and brown-out register synchronisation, voltage
 * reference control and PLL lock timer.
 * Assumes status bits arrive asynchronously from analog blocks and that
 * the calibration word is stable while reset is asserted.
 */
// Implementation choices: the register addresses and strobed register access.
// Behaviour
// - Hysteresis bit adds brown-out threshold margin in continuous and sampling modes.
// - Reset loads bandgap trim from factory calibration word.
// - Writing one to temperature sensor bit switches the sensor on.
// - Bandgap reaches converter only while its output enable bit is set.
// - Trim field sets reference level; software write replaces reset value.
// - Each of eleven status inputs sets its flag on a rising edge.
// - PLL lock flag sets when lock status becomes asserted.
// - Lock-lost flag sets on falling lock edge while PLL runs.
// - Timeout flag sets once programmed lock time elapsed since PLL start.
// - Every source owns a flag set when its condition occurs.
// - Enable-set one enables, enable-clear one disables, zeros do nothing.
// - Request active while flag and enable both set.
// - All requests ORed onto one line; software reads flags for cause.
// - Locked-loop control writes ignored while its ready bit is zero.
// - Software requests read sync first and reads after ready.
// - Read without prior request starts sync and holds bus until done.
// - Locked-loop reads while it is disabled complete without holding.
// - Brown-out register writes pass a sync delay before taking effect.
// - Brown-out write clears sync-ready, sets it again on completion.
// - During brown-out sync, further write or read holds the bus.
// - Held access completes after the pending sync finishes.
// - Writing one to a flag clears it; zero leaves it.
// - Brown-out writes beyond the one held slot are ignored while not ready.
`timescale 1ns/1ps

module scu_irq_sync (
   input  wire logic                clock,          // Bus clock, 50 MHz
   input  wire logic                rst_n,          // Synchronous reset, active low
   input  wire scu_pkg::scu_bus_req_t busReq,       // Register access request
   output logic [31:0]              rdData,         // Read data
   output logic                     rdValid,        // Read data valid pulse
   output logic                     busWait,        // Access held for sync
   input  wire logic [10:0]         statusIn,       // Async analog status bits
   input  wire logic                pllLockIn,      // Async PLL lock status
   input  wire logic [10:0]         calibWord,      // Factory bandgap trim
   output logic                     irqLine,        // Combined interrupt request
   output logic                     thresholdMargin,// Brown-out hysteresis
   output logic                     brownoutSampled,// Brown-out sampling mode
   output logic                     tempSensorOn,   // Temperature sensor enable
   output logic                     bandgapToAdc,   // Bandgap routed to converter
   output logic [10:0]              bandgapTrim,    // Reference trim
   output logic                     pllEnable,      // PLL run
   output logic                     fllEnable       // Locked loop run
);

   typedef struct packed {
      logic [11:0]         sync1;
      logic [11:0]         sync2;
      logic [11:0]         prev;
      logic [17:0]         flags;
      logic [17:0]         enables;
      logic                irq;
      logic [31:0]         rdData;
      logic                rdValid;
      logic                busWait;
      logic                heldRd;
      logic [7:0]          heldAddr;
      logic [15:0]         fllCtrl;
      logic [31:0]         fllVal;
      logic [31:0]         fllMul;
      scu_pkg::scu_fll_st_t fllSt;
      logic [3:0]          fllCnt;
      logic                fllSynced;
      logic [15:0]         bodShadow;
      logic [15:0]         bodLive;
      logic [3:0]          bodCnt;
      logic                bodSyncRdy;
      logic                bodPend;
      logic [15:0]         bodPendData;
      logic                tsen;
      logic                bgOut;
      logic [10:0]         trim;
      logic                pllEn;
      logic [2:0]          ltime;
      logic [11:0]         pllTimer;
      logic                pllTimerRun;
   } scu_state_t;

   scu_state_t s_q;
   scu_state_t s_d;

   logic [17:0] setEv;
   logic [17:0] clrEv;
   logic [31:0] rdMux;
   logic [31:0] statusWord;
   logic        fllAddr;

   // ==========================================================
   // Flag set events from synchronised status and the lock timer
   always_comb begin
      setEv = '0;
      // Compare second sync stage against its own delayed copy
      setEv[11:0] = s_q.sync2 & ~s_q.prev;
      setEv[scu_pkg::BIT_BOD_SYNC_RDY] = 1'b0;  // Taken from the next state below
      setEv[scu_pkg::BIT_PLL_LOCK] = s_q.sync2[11] & ~s_q.prev[11];
      // Lost lock only counts while the PLL is meant to be running
      setEv[scu_pkg::BIT_PLL_LOST] = s_q.pllEn & ~s_q.sync2[11] & s_q.prev[11];
      setEv[scu_pkg::BIT_PLL_TIMEOUT] = s_q.pllTimerRun && s_q.pllTimer == 12'h001;
   end

   // Status word as software sees it
   always_comb begin
      statusWord = '0;
      statusWord[10:0] = s_q.sync2[10:0];
      statusWord[scu_pkg::BIT_BOD_SYNC_RDY] = s_q.bodSyncRdy;
      statusWord[scu_pkg::BIT_PLL_LOCK] = s_q.sync2[11];
   end

   // ==========================================================
   // Read multiplexer
   always_comb begin
      rdMux = '0;
      if (busReq.addr == scu_pkg::ADDR_IRQ_EN_CLR || busReq.addr == scu_pkg::ADDR_IRQ_EN_SET) begin
         rdMux[17:0] = s_q.enables;
      end else if (busReq.addr == scu_pkg::ADDR_IRQ_FLAG) begin
         rdMux[17:0] = s_q.flags;
      end else if (busReq.addr == scu_pkg::ADDR_PWR_CLK_STAT) begin
         rdMux = statusWord;
      end else if (busReq.addr == scu_pkg::ADDR_FLL_CTRL) begin
         rdMux[15:0] = s_q.fllCtrl;
      end else if (busReq.addr == scu_pkg::ADDR_FLL_VAL) begin
         rdMux = s_q.fllVal;
      end else if (busReq.addr == scu_pkg::ADDR_FLL_MUL) begin
         rdMux = s_q.fllMul;
      end else if (busReq.addr == scu_pkg::ADDR_BROWNOUT) begin
         rdMux[15:0] = s_q.bodLive;
      end else if (busReq.addr == scu_pkg::ADDR_VREF) begin
         rdMux[scu_pkg::TEMP_SENSOR_ON_BIT_BIT] = s_q.tsen;
         rdMux[scu_pkg::VREF_BGOUT_BIT] = s_q.bgOut;
         rdMux[scu_pkg::VREF_TRIM_LSB +: 11] = s_q.trim;
      end else if (busReq.addr == scu_pkg::ADDR_PLL_CTRL) begin
         rdMux[scu_pkg::PLL_EN_BIT] = s_q.pllEn;
         rdMux[scu_pkg::PLL_LTIME_LSB +: 3] = s_q.ltime;
      end
   end

   assign fllAddr = busReq.addr == scu_pkg::ADDR_FLL_CTRL ||
                    busReq.addr == scu_pkg::ADDR_FLL_VAL  ||
                    busReq.addr == scu_pkg::ADDR_FLL_MUL;

   // ==========================================================
   // Next state
   always_comb begin
      s_d = s_q;
      clrEv = '0;
      s_d.rdValid = 1'b0;

      // Two-flop synchronisers, then one delayed copy for edges
      s_d.sync1 = {pllLockIn, statusIn};
      s_d.sync2 = s_q.sync1;
      s_d.prev  = s_q.sync2;

      // Brown-out write synchronisation countdown
      if (!s_q.bodSyncRdy) begin
         if (s_q.bodCnt == 4'h1) begin
            s_d.bodLive = s_q.bodShadow;
            if (s_q.bodPend) begin
               // Queued write starts its own sync straight away
               s_d.bodShadow = s_q.bodPendData;
               s_d.bodPend = 1'b0;
               s_d.bodCnt = 4'(scu_pkg::BOD_SYNC_CYC);
            end else begin
               s_d.bodSyncRdy = 1'b1;
            end
         end else begin
            s_d.bodCnt = s_q.bodCnt - 4'h1;
         end
      end

      // Locked-loop read synchronisation
      case (s_q.fllSt)
         scu_pkg::FLL_IDLE: begin
         end
         scu_pkg::FLL_SYNC: begin
            if (s_q.fllCnt == 4'h1) begin
               s_d.fllSt = scu_pkg::FLL_IDLE;
               s_d.fllSynced = 1'b1;
               s_d.fllCtrl[scu_pkg::FLL_RDREQ_BIT] = 1'b0;
            end else begin
               s_d.fllCnt = s_q.fllCnt - 4'h1;
            end
         end
         default: s_d.fllSt = scu_pkg::FLL_IDLE;
      endcase

      // Held read completes once the sync it waits on is done
      if (s_q.heldRd) begin
         if (s_q.heldAddr == scu_pkg::ADDR_BROWNOUT && s_d.bodSyncRdy) begin
            s_d.rdData = {16'h0000, s_d.bodLive};
            s_d.rdValid = 1'b1;
            s_d.heldRd = 1'b0;
         end else if (s_q.heldAddr != scu_pkg::ADDR_BROWNOUT &&
                      s_d.fllSt == scu_pkg::FLL_IDLE) begin
            s_d.rdData = 32'h0;
            if (s_q.heldAddr == scu_pkg::ADDR_FLL_CTRL) begin
               s_d.rdData[15:0] = s_q.fllCtrl;
            end else if (s_q.heldAddr == scu_pkg::ADDR_FLL_VAL) begin
               s_d.rdData = s_q.fllVal;
            end else begin
               s_d.rdData = s_q.fllMul;
            end
            s_d.rdValid = 1'b1;
            s_d.heldRd = 1'b0;
            s_d.fllSynced = 1'b0;
         end
      end

      // Register reads
      if (busReq.rd) begin
         if (busReq.addr == scu_pkg::ADDR_BROWNOUT && !s_q.bodSyncRdy) begin
            s_d.heldRd = 1'b1;
            s_d.heldAddr = busReq.addr;
         end else if (fllAddr && s_q.fllCtrl[scu_pkg::FLL_EN_BIT] && !s_q.fllSynced) begin
            // No earlier read request: start a sync and hold the read
            s_d.heldRd = 1'b1;
            s_d.heldAddr = busReq.addr;
            if (s_q.fllSt == scu_pkg::FLL_IDLE) begin
               s_d.fllSt = scu_pkg::FLL_SYNC;
               s_d.fllCnt = 4'(scu_pkg::FLL_SYNC_CYC);
            end
         end else begin
            s_d.rdData = rdMux;
            s_d.rdValid = 1'b1;
            if (fllAddr) begin
               s_d.fllSynced = 1'b0;
            end
         end
      end

      // Register writes
      if (busReq.wr) begin
         if (busReq.addr == scu_pkg::ADDR_IRQ_EN_CLR) begin
            s_d.enables = s_q.enables & ~busReq.wdata[17:0];
         end else if (busReq.addr == scu_pkg::ADDR_IRQ_EN_SET) begin
            s_d.enables = s_q.enables | busReq.wdata[17:0];
         end else if (busReq.addr == scu_pkg::ADDR_IRQ_FLAG) begin
            clrEv = busReq.wdata[17:0];
         end else if (fllAddr || busReq.addr == scu_pkg::ADDR_FLL_SYNC) begin
            // Locked-loop writes are dropped until it reports ready
            if (s_q.sync2[scu_pkg::BIT_FLL_READY]) begin
               if (busReq.addr == scu_pkg::ADDR_FLL_CTRL) begin
                  s_d.fllCtrl = busReq.wdata[15:0];
                  s_d.fllCtrl[scu_pkg::FLL_RDREQ_BIT] = 1'b0;
               end else if (busReq.addr == scu_pkg::ADDR_FLL_VAL) begin
                  s_d.fllVal = busReq.wdata;
               end else if (busReq.addr == scu_pkg::ADDR_FLL_MUL) begin
                  s_d.fllMul = busReq.wdata;
               end else if (busReq.wdata[scu_pkg::FLL_RDREQ_BIT]) begin
                  s_d.fllSt = scu_pkg::FLL_SYNC;
                  s_d.fllCnt = 4'(scu_pkg::FLL_SYNC_CYC);
                  s_d.fllSynced = 1'b0;
               end
            end
         end else if (busReq.addr == scu_pkg::ADDR_BROWNOUT) begin
            // Next-state view, so a write in the cycle a sync ends is not lost
            if (s_d.bodSyncRdy) begin
               s_d.bodShadow = busReq.wdata[15:0];
               s_d.bodSyncRdy = 1'b0;
               s_d.bodCnt = 4'(scu_pkg::BOD_SYNC_CYC);
            end else if (!s_d.bodPend) begin
               s_d.bodPend = 1'b1;
               s_d.bodPendData = busReq.wdata[15:0];
            end
            // A second write while one is already queued is dropped
         end else if (busReq.addr == scu_pkg::ADDR_VREF) begin
            s_d.tsen = busReq.wdata[scu_pkg::TEMP_SENSOR_ON_BIT_BIT];
            s_d.bgOut = busReq.wdata[scu_pkg::VREF_BGOUT_BIT];
            s_d.trim = busReq.wdata[scu_pkg::VREF_TRIM_LSB +: 11];
         end else if (busReq.addr == scu_pkg::ADDR_PLL_CTRL) begin
            s_d.pllEn = busReq.wdata[scu_pkg::PLL_EN_BIT];
            s_d.ltime = busReq.wdata[scu_pkg::PLL_LTIME_LSB +: 3];
            // Lock timer starts on the PLL start when a time is set
            if (!s_q.pllEn && busReq.wdata[scu_pkg::PLL_EN_BIT] &&
                busReq.wdata[scu_pkg::PLL_LTIME_LSB +: 3] != 3'h0) begin
               s_d.pllTimerRun = 1'b1;
               s_d.pllTimer = 12'(busReq.wdata[scu_pkg::PLL_LTIME_LSB +: 3] *
                                  scu_pkg::LTIME_UNIT_CYC);
            end
            if (!busReq.wdata[scu_pkg::PLL_EN_BIT]) begin
               s_d.pllTimerRun = 1'b0;
            end
         end
      end

      // Lock timer countdown
      if (s_q.pllTimerRun && !(busReq.wr && busReq.addr == scu_pkg::ADDR_PLL_CTRL)) begin
         s_d.pllTimer = s_q.pllTimer - 12'h001;
         if (s_q.pllTimer == 12'h001) begin
            s_d.pllTimerRun = 1'b0;
         end
      end

      // Set wins over a clear in the same cycle
      s_d.flags = (s_q.flags & ~clrEv) | setEv;
      // Sync-ready rise is known only here; reading it earlier would close a loop
      s_d.flags[scu_pkg::BIT_BOD_SYNC_RDY] |= s_d.bodSyncRdy & ~s_q.bodSyncRdy;
      // Registered OR of every enabled flag
      s_d.irq = |(s_d.flags & s_d.enables);
      s_d.busWait = s_d.heldRd | s_d.bodPend;
   end

   // ==========================================================
   // State register
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         s_q <= '0;
         s_q.fllCtrl <= scu_pkg::FLL_CTRL_RST;
         s_q.bodShadow <= scu_pkg::BOD_RST;
         s_q.bodLive <= scu_pkg::BOD_RST;
         s_q.bodSyncRdy <= 1'b1;
         s_q.flags <= scu_pkg::FLAG_RST;
         s_q.fllSt <= scu_pkg::FLL_IDLE;
         s_q.trim <= calibWord;
      end else begin
         s_q <= s_d;
      end
   end

   // ==========================================================
   // Outputs, each straight from the state register
   assign rdData          = s_q.rdData;
   assign rdValid         = s_q.rdValid;
   assign busWait         = s_q.busWait;
   assign irqLine         = s_q.irq;
   assign thresholdMargin = s_q.bodLive[scu_pkg::BOD_HYST_BIT];
   assign brownoutSampled = s_q.bodLive[scu_pkg::BOD_MODE_BIT];
   assign tempSensorOn    = s_q.tsen;
   assign bandgapToAdc    = s_q.bgOut;
   assign bandgapTrim     = s_q.trim;
   assign pllEnable       = s_q.pllEn;
   assign fllEnable       = s_q.fllCtrl[scu_pkg::FLL_EN_BIT];

endmodule

/* shared/scu_pkg.sv */
/*
 * Constants and types shared by the system control unit interrupt and
 * synchronisation block: register byte addresses, flag positions, reset
 * values, synchronisation delays and the bus request carrier.
 * Assumes a single 50 MHz bus clock.
 */
package scu_pkg;

   // ==========================================================
   // Clock and timing
   localparam int unsigned CLK_MHZ          = 50;
   localparam int unsigned LTIME_UNIT_NS    = 1000;
   localparam int unsigned LTIME_UNIT_CYC   = (LTIME_UNIT_NS * CLK_MHZ) / 1000;
   localparam int unsigned FLL_SYNC_CYC     = 6;
   localparam int unsigned BOD_SYNC_CYC     = 8;

   // ==========================================================
   // Register byte addresses
   localparam logic [7:0] ADDR_IRQ_EN_CLR   = 8'h00;
   localparam logic [7:0] ADDR_IRQ_EN_SET   = 8'h04;
   localparam logic [7:0] ADDR_IRQ_FLAG     = 8'h08;
   localparam logic [7:0] ADDR_PWR_CLK_STAT = 8'h0c;
   localparam logic [7:0] ADDR_FLL_CTRL     = 8'h24;
   localparam logic [7:0] ADDR_FLL_VAL      = 8'h28;
   localparam logic [7:0] ADDR_FLL_MUL      = 8'h2c;
   localparam logic [7:0] ADDR_FLL_SYNC     = 8'h30;
   localparam logic [7:0] ADDR_BROWNOUT     = 8'h34;
   localparam logic [7:0] ADDR_VREF         = 8'h40;
   localparam logic [7:0] ADDR_PLL_CTRL     = 8'h44;

   // ==========================================================
   // Flag positions (status bits 0..10 are edge sources)
   localparam int unsigned NFLAG            = 18;
   localparam int unsigned NSTAT            = 11;
   localparam int unsigned BIT_FLL_READY    = 4;
   localparam int unsigned BIT_BOD_SYNC_RDY = 11;
   localparam int unsigned BIT_PLL_LOCK     = 15;
   localparam int unsigned BIT_PLL_LOST     = 16;
   localparam int unsigned BIT_PLL_TIMEOUT  = 17;

   // ==========================================================
   // Field positions
   localparam int unsigned FLL_EN_BIT       = 1;
   localparam int unsigned FLL_RDREQ_BIT    = 7;
   localparam int unsigned BOD_HYST_BIT     = 2;
   localparam int unsigned BOD_MODE_BIT     = 8;
   localparam int unsigned TEMP_SENSOR_ON_BIT_BIT    = 1;
   localparam int unsigned VREF_BGOUT_BIT   = 2;
   localparam int unsigned VREF_TRIM_LSB    = 16;
   localparam int unsigned PLL_EN_BIT       = 1;
   localparam int unsigned PLL_LTIME_LSB    = 8;

   // ==========================================================
   // Reset values
   localparam logic [15:0] FLL_CTRL_RST     = 16'h0080;
   localparam logic [15:0] BOD_RST          = 16'h0000;
   localparam logic [17:0] FLAG_RST         = 18'h00000;

   typedef struct packed {
      logic        wr;
      logic        rd;
      logic [7:0]  addr;
      logic [31:0] wdata;
   } scu_bus_req_t;

   typedef enum logic {FLL_IDLE, FLL_SYNC} scu_fll_st_t;

endpackage

/* tb/scu_irq_sync_properties.sv */
/* Port checker for the interrupt and synchronisation block.
   Assumes one bus clock and the synchronous active-low reset. */
`timescale 1ns/1ps
module scu_irq_sync_properties (
   input wire logic                  clock,           // Bus clock
   input wire logic                  rst_n,           // Reset, active low
   input wire scu_pkg::scu_bus_req_t busReq,          // Register request
   input wire logic                  rdValid,         // Read answer
   input wire logic                  busWait,         // Held access
   input wire logic [10:0]           statusIn,        // Status levels
   input wire logic [10:0]           calibWord,       // Factory trim
   input wire logic                  irqLine,         // Combined request
   input wire logic                  thresholdMargin, // Hysteresis
   input wire logic                  brownoutSampled, // Sampling mode
   input wire logic                  tempSensorOn,    // Sensor on
   input wire logic                  bandgapToAdc,    // Bandgap routing
   input wire logic [10:0]           bandgapTrim,     // Trim
   input wire logic                  fllEnable        // Locked loop run
);
   // ==========================================
   // Helper: cycles the loop ready input stayed low
   logic [2:0] lowCnt_q;
   always_ff @(posedge clock) begin
      if (!rst_n || statusIn[scu_pkg::BIT_FLL_READY]) lowCnt_q <= 3'h0;
      else if (lowCnt_q != 3'h7) lowCnt_q <= lowCnt_q + 3'h1;
   end
   // Helpers: cycles since a brown-out write, and an unused loop read request
   logic [4:0] bodIdle_q;
   logic       reqSeen_q;
   always_ff @(posedge clock) begin
      if (!rst_n || busReq.wr && busReq.addr == 8'h34) bodIdle_q <= 5'h00;
      else if (bodIdle_q != 5'h1f) bodIdle_q <= bodIdle_q + 5'h01;
      if (!rst_n || busReq.rd && busReq.addr[7:4] == 4'h2) reqSeen_q <= 1'b0;
      else if (busReq.wr && busReq.addr == 8'h30) reqSeen_q <= 1'b1;
   end
   default clocking @(posedge clock); endclocking
   default disable iff (!rst_n);
   sequence s_wr(logic [7:0] a); busReq.wr && busReq.addr == a; endsequence
   sequence s_rd(logic [7:0] a); busReq.rd && busReq.addr == a; endsequence
   // ==========================================
   // Properties
   property p_trim_reset; $rose(rst_n) |-> bandgapTrim == $past(calibWord); endproperty
   a_trim_reset: assert property (p_trim_reset) else $error("trim not loaded");
   property p_tsen; s_wr(8'h40) |=> tempSensorOn == $past(busReq.wdata[1]); endproperty
   a_tsen: assert property (p_tsen) else $error("sensor bit wrong");
   property p_bgout; s_wr(8'h40) |=> bandgapToAdc == $past(busReq.wdata[2]); endproperty
   a_bgout: assert property (p_bgout) else $error("bandgap routing wrong");
   property p_trim_wr; s_wr(8'h40) |=> bandgapTrim == $past(busReq.wdata[26:16]); endproperty
   a_trim_wr: assert property (p_trim_wr) else $error("trim write lost");
   property p_en_clr;
      s_wr(8'h00) ##0 busReq.wdata[17:0] == 18'h3ffff ##1 !busReq.wr |=> !irqLine;
   endproperty
   a_en_clr: assert property (p_en_clr) else $error("request after disable");
   property p_fll_ign; s_wr(8'h24) ##0 lowCnt_q == 3'h7 |=> $stable(fllEnable); endproperty
   a_fll_ign: assert property (p_fll_ign) else $error("write taken while not ready");
   property p_fll_held;
      s_rd(8'h24) ##0 fllEnable && !reqSeen_q |=> busWait ##[0:7] rdValid;
   endproperty
   a_fll_held: assert property (p_fll_held) else $error("held read not answered");
   property p_fll_off; s_rd(8'h24) ##0 !fllEnable |=> rdValid; endproperty
   a_fll_off: assert property (p_fll_off) else $error("read stalled while off");
   sequence s_bod_alone;
      s_wr(8'h34) ##0 !busWait && bodIdle_q >= 5'h10 ##1 !busReq.wr [*8];
   endsequence
   property p_bod;
      s_bod_alone |-> ##4 thresholdMargin == $past(busReq.wdata[2], 12)
         && brownoutSampled == $past(busReq.wdata[8], 12);
   endproperty
   a_bod: assert property (p_bod) else $error("brown-out bits not applied");
   property p_bod_hold; s_wr(8'h34) ##0 !busWait ##[1:6] s_wr(8'h34) |=> busWait; endproperty
   a_bod_hold: assert property (p_bod_hold) else $error("second write not held");
endmodule
bind scu_irq_sync scu_irq_sync_properties u_props (.clock, .rst_n, .busReq, .rdValid,
   .busWait, .statusIn, .calibWord, .irqLine, .thresholdMargin, .brownoutSampled,
   .tempSensorOn, .bandgapToAdc, .bandgapTrim, .fllEnable);

/* tb/scu_status_model.sv */
/* Analog status sources: oscillator, loop and brown-out ready levels.
   Assumes the bench asks for levels; they move on the falling edge. */
`timescale 1ns/1ps
module scu_status_model (
   input  wire logic        clock,      // Bus clock
   input  wire logic [10:0] wantStatus, // Levels asked for
   input  wire logic        wantLock,   // Lock level asked for
   input  wire logic        slow,       // Settle late instead of at once
   output logic      [10:0] statusIn,   // Status toward the unit
   output logic             pllLockIn   // Lock toward the unit
);
   logic [2:0] age;
   initial begin
      statusIn = 11'h0;
      pllLockIn = 1'b0;
      age = 3'h0;
   end
   // ==========================================
   // Off the rising edge, as free-running analog flags would be
   always @(negedge clock) begin
      if ({wantStatus, wantLock} == {statusIn, pllLockIn}) age = 3'h0;
      else if (age >= (slow ? 3'h3 : 3'h0)) begin
         statusIn = wantStatus;
         pllLockIn = wantLock;
         age = 3'h0;
      end else age = age + 3'h1;
   end
endmodule

/* tb/tb.sv */
/* Self-checking bench for the interrupt and synchronisation block.
   Assumes the plain strobe register port and the status source model. */
`timescale 1ns/1ps
module tb;
   logic                  clock = 1'b0;
   logic                  rst_n = 1'b0;
   scu_pkg::scu_bus_req_t busReq = '0;
   logic [10:0]           wantStatus = 11'h0;
   logic                  wantLock = 1'b0;
   logic                  slow = 1'b0;
   logic [10:0]           calibWord = 11'h5a3;
   logic [31:0]           rdData, got;
   logic [10:0]           statusIn, bandgapTrim;
   logic                  rdValid, busWait, pllLockIn, irqLine, thresholdMargin;
   logic                  brownoutSampled, tempSensorOn, bandgapToAdc, pllEnable, fllEnable;
   int                    errors = 0;
   int                    check_count = 0;
   int                    n;
   always #10 clock = ~clock;
   scu_irq_sync dut (.clock(clock), .rst_n(rst_n), .busReq(busReq), .rdData(rdData),
      .rdValid(rdValid), .busWait(busWait), .statusIn(statusIn), .pllLockIn(pllLockIn),
      .calibWord(calibWord), .irqLine(irqLine), .thresholdMargin(thresholdMargin),
      .brownoutSampled(brownoutSampled), .tempSensorOn(tempSensorOn),
      .bandgapToAdc(bandgapToAdc), .bandgapTrim(bandgapTrim), .pllEnable(pllEnable),
      .fllEnable(fllEnable));
   scu_status_model u_src (.clock(clock), .wantStatus(wantStatus), .wantLock(wantLock),
      .slow(slow), .statusIn(statusIn), .pllLockIn(pllLockIn));
   // ==========================================
   // Bus tasks and comparison
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      check_count++;
      if (g !== e) begin
         errors++;
         $display("wrong value at %0t: got %h expected %h", $time, g, e);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clock);
      busReq <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
      @(posedge clock);
      busReq.wr <= 1'b0;
      #1;
   endtask
   // Held reads answer late, so the wait is bounded rather than fixed
   task automatic rd(input logic [7:0] a);
      @(posedge clock);
      busReq <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 32'h0};
      @(posedge clock);
      busReq.rd <= 1'b0;
      #1;
      for (n = 0; n < 24 && rdValid !== 1'b1; n++) @(posedge clock) #1;
      got = (rdValid === 1'b1) ? rdData : 32'hxxxxxxxx;
   endtask
   task automatic tick(input int c);
      repeat (c) @(posedge clock);
      #1;
   endtask
   task automatic stop_test;
      $display("checks %0d mismatches %0d", check_count, errors);
      if (errors == 0 && check_count > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   // ==========================================
   // Watchdog: the sequence needs well under a thousand cycles
   initial begin
      #100000;
      errors++;
      stop_test();
   end
   // ==========================================
   // Test sequence
   initial begin
      repeat (16) @(posedge clock);
      rst_n <= 1'b1;
      tick(1);
      chk({21'h0, bandgapTrim}, {21'h0, calibWord});
      rd(scu_pkg::ADDR_FLL_CTRL);
      chk(got, 32'h80);
      rd(8'hfc);
      chk(got, 32'h0);
      wr(scu_pkg::ADDR_IRQ_FLAG, 32'h3ffff);
      wr(scu_pkg::ADDR_VREF, 32'h02a5_0006);
      chk({21'h0, bandgapTrim}, 32'h2a5);
      chk({30'h0, bandgapToAdc, tempSensorOn}, 32'h3);
      wr(scu_pkg::ADDR_VREF, 32'h2);
      chk({30'h0, bandgapToAdc, tempSensorOn}, 32'h1);
      $display("test reset and reference done");
      wr(scu_pkg::ADDR_PLL_CTRL, 32'h2);
      wantStatus = 11'h7ff;
      wantLock = 1'b1;
      tick(8);
      rd(scu_pkg::ADDR_IRQ_FLAG);
      chk(got, 32'h87ff);
      chk({31'h0, irqLine}, 32'h0);
      wr(scu_pkg::ADDR_IRQ_EN_SET, 32'h1);
      tick(2);
      chk({31'h0, irqLine}, 32'h1);
      wr(scu_pkg::ADDR_IRQ_EN_CLR, 32'h0);
      tick(2);
      chk({31'h0, irqLine}, 32'h1);
      wr(scu_pkg::ADDR_IRQ_EN_CLR, 32'h3ffff);
      tick(2);
      chk({31'h0, irqLine}, 32'h0);
      wr(scu_pkg::ADDR_IRQ_EN_SET, 32'h1);
      wr(scu_pkg::ADDR_IRQ_FLAG, 32'h1);
      tick(2);
      chk({31'h0, irqLine}, 32'h0);
      rd(scu_pkg::ADDR_IRQ_FLAG);
      chk(got, 32'h87fe);
      wantLock = 1'b0;
      tick(8);
      rd(scu_pkg::ADDR_IRQ_FLAG);
      chk(got, 32'h187fe);
      wr(scu_pkg::ADDR_PLL_CTRL, 32'h0);
      wr(scu_pkg::ADDR_PLL_CTRL, 32'h102);
      tick(40);
      rd(scu_pkg::ADDR_IRQ_FLAG);
      chk({30'h0, pllEnable, got[17]}, 32'h2);
      tick(20);
      rd(scu_pkg::ADDR_IRQ_FLAG);
      chk({31'h0, got[17]}, 32'h1);
      $display("test flags and request line done");
      wr(scu_pkg::ADDR_FLL_CTRL, 32'h2);
      chk({31'h0, fllEnable}, 32'h1);
      rd(scu_pkg::ADDR_FLL_CTRL);
      chk({31'h0, got[1]}, 32'h1);
      wr(scu_pkg::ADDR_FLL_MUL, 32'h1234_5678);
      wr(scu_pkg::ADDR_FLL_SYNC, 32'h80);
      tick(8);
      rd(scu_pkg::ADDR_FLL_MUL);
      chk(got, 32'h1234_5678);
      chk(n, 32'h0);
      slow = 1'b1;
      wantStatus = 11'h7ef;
      tick(12);
      wr(scu_pkg::ADDR_FLL_CTRL, 32'h0);
      chk({31'h0, fllEnable}, 32'h1);
      wantStatus = 11'h7ff;
      $display("test locked loop access done");
      wr(scu_pkg::ADDR_BROWNOUT, 32'h104);
      wr(scu_pkg::ADDR_BROWNOUT, 32'h0);
      chk({31'h0, busWait}, 32'h1);
      for (n = 0; n < 20 && thresholdMargin !== 1'b1; n++) tick(1);
      chk({30'h0, brownoutSampled, thresholdMargin}, 32'h3);
      for (n = 0; n < 20 && thresholdMargin !== 1'b0; n++) tick(1);
      chk({30'h0, brownoutSampled, busWait}, 32'h0);
      rd(scu_pkg::ADDR_IRQ_FLAG);
      chk({31'h0, got[11]}, 32'h1);
      wr(scu_pkg::ADDR_BROWNOUT, 32'h4);
      tick(14);
      chk({30'h0, brownoutSampled, thresholdMargin}, 32'h1);
      $display("test brown-out sync done");
      stop_test();
   end
endmodule
